/* src/sdbc_pkg.sv */
// sdbc_pkg: shared constants, types and timing counts for the bank
// command state tracker. Assumes a single 50 MHz clock (20 ns period).
package sdbc_pkg;

  localparam int CLK_PERIOD_PS = 20000;
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 11;
  localparam int AUTO_PRE_BIT = 10; // auto_precharge_addr_bit position
  localparam int TMR_W = 8;
  localparam int BURST_W = 3;

  // timing figures; plain defaults, the real part's values are set here
  localparam int PRECHARGE_PERIOD_NS = 20;
  localparam int ACTIVATE_TO_COLUMN_NS = 20;
  localparam int REFRESH_CYCLE_NS = 70;
  localparam int SELF_REFRESH_EXIT_NS = 80;
  localparam int MODE_REG_DELAY_CLKS = 2;
  localparam int BURST_LEN = 4;

  // least time in ns to whole cycles, rounded up, never below one
  function automatic int sdbc_min_cycles(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : sdbc_min_cycles

  // timer loads are count minus one: zero means elapsed at the next edge
  localparam logic [TMR_W-1:0] PRECHARGE_LOAD =
    TMR_W'(sdbc_min_cycles(PRECHARGE_PERIOD_NS) - 1);
  localparam logic [TMR_W-1:0] ACT_TO_COL_LOAD =
    TMR_W'(sdbc_min_cycles(ACTIVATE_TO_COLUMN_NS) - 1);
  localparam logic [TMR_W-1:0] REFRESH_LOAD =
    TMR_W'(sdbc_min_cycles(REFRESH_CYCLE_NS) - 1);
  localparam logic [TMR_W-1:0] SR_EXIT_LOAD =
    TMR_W'(sdbc_min_cycles(SELF_REFRESH_EXIT_NS) - 1);
  localparam logic [TMR_W-1:0] MODE_LOAD_LOAD = TMR_W'(MODE_REG_DELAY_CLKS - 1);
  localparam logic [BURST_W-1:0] BURST_LOAD = BURST_W'(BURST_LEN - 1);
  localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;
  localparam logic [BURST_W-1:0] BURST_ZERO = 3'h0;

  // {row strobe, column strobe, write enable} codes, active low
  localparam logic [2:0] CODE_NOP = 3'h7;
  localparam logic [2:0] CODE_ACT = 3'h3;
  localparam logic [2:0] CODE_READ = 3'h5;
  localparam logic [2:0] CODE_WRITE = 3'h4;
  localparam logic [2:0] CODE_STOP = 3'h6;
  localparam logic [2:0] CODE_PRE = 3'h2;
  localparam logic [2:0] CODE_REF = 3'h1;
  localparam logic [2:0] CODE_LMR = 3'h0;

  typedef struct packed {
    logic chipSelN;
    logic rowStrobeN;
    logic colStrobeN;
    logic writeEnN;
    logic cke;
    logic [BANK_W-1:0] bankSelect;
    logic [ADDR_W-1:0] addr;
  } sdbc_pins_t;

  localparam sdbc_pins_t PINS_RESET =
    sdbc_pins_t'({4'hF, 1'h0, 2'h0, 11'h000});

  typedef enum logic [3:0] {
    CMD_INHIBIT, CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE,
    CMD_BURST_STOP, CMD_PRECHARGE, CMD_REFRESH, CMD_LOAD_MODE
  } sdbc_cmd_t;

  typedef enum logic [7:0] {
    BK_IDLE = 8'h01,
    BK_ACTIVATING = 8'h02,
    BK_ROW_ACTIVE = 8'h04,
    BK_READING = 8'h08,
    BK_WRITING = 8'h10,
    BK_READ_AP = 8'h20,
    BK_WRITE_AP = 8'h40,
    BK_PRECHARGING = 8'h80
  } sdbc_bank_st_t;

  typedef enum logic [5:0] {
    DEV_NORMAL = 6'h01,
    DEV_REFRESH = 6'h02,
    DEV_MODE_LOAD = 6'h04,
    DEV_PRE_ALL = 6'h08,
    DEV_SELF_REFRESH = 6'h10,
    DEV_SR_EXIT = 6'h20
  } sdbc_dev_st_t;

  typedef sdbc_bank_st_t [NUM_BANKS-1:0] sdbc_bank_vec_t;

  typedef struct packed {
    sdbc_cmd_t cmd;
    logic autoPre;
    logic [BANK_W-1:0] bank;
    logic tablesOn;
    logic selfRefEntry;
    logic ckeNow;
  } sdbc_dec_t;

  typedef struct packed {
    sdbc_bank_vec_t bankState;
    sdbc_dev_st_t devState;
    logic burstActive;
    logic [BANK_W-1:0] burstBank;
  } sdbc_status_t;

endpackage : sdbc_pkg

/* src/sdbc_pin_sync.sv */
// sdbc_pin_sync: two-flop synchroniser for the command pins.
// Assumes pins are asynchronous to ref_clk; reset is synchronous.
`timescale 1ns/1ps
`default_nettype none
module sdbc_pin_sync
  import sdbc_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic reset, // synchronous, active high
  input wire sdbc_pkg::sdbc_pins_t pinsIn, // raw pins
  output sdbc_pkg::sdbc_pins_t pinsOut // synchronised pins
);
  import sdbc_pkg::*;

  sdbc_pins_t stage1_q;
  sdbc_pins_t stage2_q;

  // first stage feeds only the second; reset parks pins as inhibit
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage1_q <= PINS_RESET;
      stage2_q <= PINS_RESET;
    end else begin
      stage1_q <= pinsIn;
      stage2_q <= stage1_q;
    end
  end

  assign pinsOut = stage2_q;
endmodule : sdbc_pin_sync
`default_nettype wire

/* src/sdbc_cmd_decode.sv */
// sdbc_cmd_decode: turns synchronised pins into one command.
// Assumes pins and previous clock enable are on ref_clk already.
`timescale 1ns/1ps
`default_nettype none
module sdbc_cmd_decode
  import sdbc_pkg::*;
(
  input wire sdbc_pkg::sdbc_pins_t pins, // synchronised pins
  input wire logic ckePrev, // clock enable at previous edge
  output sdbc_pkg::sdbc_dec_t dec // decoded command
);
  import sdbc_pkg::*;

  wire logic [2:0] code;
  sdbc_cmd_t cmd;

  assign code = {pins.rowStrobeN, pins.colStrobeN, pins.writeEnN};

  // chip select high masks the strobe and write enable code
  assign cmd = pins.chipSelN ? CMD_INHIBIT :
               (code == CODE_NOP) ? CMD_NOP :
               (code == CODE_ACT) ? CMD_ACTIVATE :
               (code == CODE_READ) ? CMD_READ :
               (code == CODE_WRITE) ? CMD_WRITE :
               (code == CODE_STOP) ? CMD_BURST_STOP :
               (code == CODE_PRE) ? CMD_PRECHARGE :
               (code == CODE_REF) ? CMD_REFRESH : CMD_LOAD_MODE;

  assign dec.cmd = cmd;
  assign dec.autoPre = pins.addr[AUTO_PRE_BIT];
  assign dec.bank = pins.bankSelect;
  // tables hold only with clock enable high on both edges
  assign dec.tablesOn = ckePrev & pins.cke;
  // refresh code with enable falling enters self refresh
  assign dec.selfRefEntry = ckePrev & ~pins.cke &
                            (cmd == CMD_REFRESH);
  assign dec.ckeNow = pins.cke;
endmodule : sdbc_cmd_decode
`default_nettype wire

/* src/sdbc_bank_fsm.sv */
// sdbc_bank_fsm: per-bank and device-wide command state tracker for a
// four-bank synchronous DRAM, with a flag for each illegal command.
// Assumes a controller drives the command pins; single clock, ref_clk.
`timescale 1ns/1ps
`default_nettype none
module sdbc_bank_fsm
  import sdbc_pkg::*;
(
  input wire logic ref_clk, // 50 MHz system clock
  input wire logic reset, // synchronous, active high
  input wire logic chipSelN, // chip select, active low
  input wire logic rowStrobeN, // row strobe, active low
  input wire logic colStrobeN, // column strobe, active low
  input wire logic writeEnN, // write enable, active low
  input wire logic cke, // clock enable
  input wire logic [sdbc_pkg::BANK_W-1:0] bankSelect, // bank_select
  input wire logic [sdbc_pkg::ADDR_W-1:0] addr, // address pins
  output sdbc_pkg::sdbc_status_t status, // tracked state, registered
  output logic cmdIllegal, // pulse: last command illegal
  output logic cmdTaken // pulse: last command accepted
);
  import sdbc_pkg::*;

  sdbc_pins_t pinsRaw;
  sdbc_pins_t pinsSync;
  sdbc_dec_t dec;
  logic ckePrev_q;
  sdbc_bank_vec_t bank_q, bank_d;
  logic [NUM_BANKS-1:0][TMR_W-1:0] tmr_q, tmr_d;
  sdbc_dev_st_t dev_q, dev_d;
  logic [TMR_W-1:0] devTmr_q, devTmr_d;
  logic burstAct_q, burstAct_d;
  logic [BANK_W-1:0] burstBank_q, burstBank_d;
  logic [BURST_W-1:0] burstCnt_q, burstCnt_d;
  logic illegal_q, illegal_d;
  logic taken_q, taken_d;

  // banks that may take a column command or a precharge
  function automatic logic sdbc_col_ok(input sdbc_bank_st_t s);
    return (s == BK_ROW_ACTIVE) || (s == BK_READING) ||
           (s == BK_WRITING);
  endfunction : sdbc_col_ok

  function automatic logic sdbc_all_idle(input sdbc_bank_vec_t v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < NUM_BANKS; i++) begin
      ok = ok & (v[i] == BK_IDLE);
    end
    return ok;
  endfunction : sdbc_all_idle

  function automatic logic sdbc_all_pre_ok(input sdbc_bank_vec_t v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < NUM_BANKS; i++) begin
      ok = ok & ((v[i] == BK_IDLE) || sdbc_col_ok(v[i]));
    end
    return ok;
  endfunction : sdbc_all_pre_ok

  // state a bank takes when its burst ends or is cut off
  function automatic sdbc_bank_st_t sdbc_after_burst(
    input sdbc_bank_st_t s
  );
    sdbc_bank_st_t r;
    r = s;
    if ((s == BK_READING) || (s == BK_WRITING)) begin
      r = BK_ROW_ACTIVE;
    end else if ((s == BK_READ_AP) || (s == BK_WRITE_AP)) begin
      r = BK_PRECHARGING;
    end
    return r;
  endfunction : sdbc_after_burst

  assign pinsRaw = '{chipSelN: chipSelN, rowStrobeN: rowStrobeN,
                     colStrobeN: colStrobeN, writeEnN: writeEnN,
                     cke: cke, bankSelect: bankSelect, addr: addr};

  sdbc_pin_sync u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pinsIn(pinsRaw),
    .pinsOut(pinsSync)
  );

  sdbc_cmd_decode u_dec (
    .pins(pinsSync),
    .ckePrev(ckePrev_q),
    .dec(dec)
  );

  // next state: timers first, then burst end, then the new command
  always_comb begin
    sdbc_bank_st_t ts;
    sdbc_bank_st_t os;
    logic busyCmd;
    ts = BK_IDLE;
    os = BK_IDLE;
    busyCmd = (dec.cmd != CMD_INHIBIT) && (dec.cmd != CMD_NOP);
    bank_d = bank_q;
    tmr_d = tmr_q;
    dev_d = dev_q;
    devTmr_d = devTmr_q;
    burstAct_d = burstAct_q;
    burstBank_d = burstBank_q;
    burstCnt_d = burstCnt_q;
    illegal_d = 1'b0;
    taken_d = 1'b0;
    // per-bank timed states close when their timer has run out
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (tmr_q[b] != TMR_ZERO) begin
        tmr_d[b] = tmr_q[b] - 1'b1;
      end else if (bank_q[b] == BK_ACTIVATING) begin
        bank_d[b] = BK_ROW_ACTIVE;
      end else if (bank_q[b] == BK_PRECHARGING) begin
        bank_d[b] = BK_IDLE;
      end
    end
    // device-wide timed states
    if (devTmr_q != TMR_ZERO) begin
      devTmr_d = devTmr_q - 1'b1;
    end else if ((dev_q == DEV_REFRESH) || (dev_q == DEV_MODE_LOAD) ||
                 (dev_q == DEV_PRE_ALL) || (dev_q == DEV_SR_EXIT)) begin
      dev_d = DEV_NORMAL;
    end
    // a running burst counts down; at the end its bank moves on
    if (burstAct_q) begin
      if (burstCnt_q != BURST_ZERO) begin
        burstCnt_d = burstCnt_q - 1'b1;
      end else begin
        burstAct_d = 1'b0;
        bank_d[burstBank_q] = sdbc_after_burst(bank_q[burstBank_q]);
        if (bank_d[burstBank_q] == BK_PRECHARGING) begin
          tmr_d[burstBank_q] = PRECHARGE_LOAD;
        end
      end
    end
    ts = bank_d[dec.bank];
    os = bank_d[burstBank_d];
    if (dev_d == DEV_SELF_REFRESH) begin
      // self refresh holds until clock enable rises again
      if (dec.ckeNow) begin
        dev_d = DEV_SR_EXIT;
        devTmr_d = SR_EXIT_LOAD;
      end
    end else if (dec.selfRefEntry) begin
      if ((dev_d == DEV_NORMAL) && sdbc_all_idle(bank_d)) begin
        dev_d = DEV_SELF_REFRESH;
        taken_d = 1'b1;
      end else begin
        illegal_d = 1'b1;
      end
    end else if (!dec.tablesOn) begin
      // power-down and clock suspend: nothing is registered
    end else if (dev_d != DEV_NORMAL) begin
      illegal_d = busyCmd;
    end else begin
      case (dec.cmd)
        CMD_ACTIVATE: begin
          if (ts == BK_IDLE) begin
            bank_d[dec.bank] = BK_ACTIVATING;
            tmr_d[dec.bank] = ACT_TO_COL_LOAD;
            taken_d = 1'b1;
          end else begin
            illegal_d = 1'b1;
          end
        end
        CMD_READ, CMD_WRITE: begin
          if (sdbc_col_ok(ts)) begin
            // another bank's access cuts the current burst off
            if (burstAct_d && (burstBank_d != dec.bank)) begin
              bank_d[burstBank_d] = sdbc_after_burst(os);
              if (bank_d[burstBank_d] == BK_PRECHARGING) begin
                tmr_d[burstBank_d] = PRECHARGE_LOAD;
              end
            end
            if (dec.cmd == CMD_READ) begin
              bank_d[dec.bank] = dec.autoPre ? BK_READ_AP : BK_READING;
            end else begin
              bank_d[dec.bank] = dec.autoPre ? BK_WRITE_AP : BK_WRITING;
            end
            burstAct_d = 1'b1;
            burstBank_d = dec.bank;
            burstCnt_d = BURST_LOAD;
            taken_d = 1'b1;
          end else begin
            illegal_d = 1'b1;
          end
        end
        CMD_BURST_STOP: begin
          // bank bits are ignored: the latest burst is the one stopped
          if (burstAct_d && ((os == BK_READING) || (os == BK_WRITING))) begin
            bank_d[burstBank_d] = BK_ROW_ACTIVE;
            burstAct_d = 1'b0;
            taken_d = 1'b1;
          end else begin
            illegal_d = 1'b1;
          end
        end
        CMD_PRECHARGE: begin
          if (dec.autoPre) begin
            if (sdbc_all_pre_ok(bank_d)) begin
              dev_d = DEV_PRE_ALL;
              devTmr_d = PRECHARGE_LOAD;
              for (int b = 0; b < NUM_BANKS; b++) begin
                bank_d[b] = BK_PRECHARGING;
                tmr_d[b] = PRECHARGE_LOAD;
              end
              burstAct_d = 1'b0;
              taken_d = 1'b1;
            end else begin
              illegal_d = 1'b1;
            end
          end else if (ts == BK_IDLE) begin
            taken_d = 1'b1;
          end else if (sdbc_col_ok(ts)) begin
            // precharge truncates a burst on the same bank
            bank_d[dec.bank] = BK_PRECHARGING;
            tmr_d[dec.bank] = PRECHARGE_LOAD;
            if (burstAct_d && (burstBank_d == dec.bank)) begin
              burstAct_d = 1'b0;
            end
            taken_d = 1'b1;
          end else begin
            illegal_d = 1'b1;
          end
        end
        CMD_REFRESH, CMD_LOAD_MODE: begin
          if (sdbc_all_idle(bank_d)) begin
            dev_d = (dec.cmd == CMD_REFRESH) ? DEV_REFRESH : DEV_MODE_LOAD;
            devTmr_d = (dec.cmd == CMD_REFRESH) ? REFRESH_LOAD :
                       MODE_LOAD_LOAD;
            taken_d = 1'b1;
          end else begin
            illegal_d = 1'b1;
          end
        end
        CMD_INHIBIT, CMD_NOP: begin
          taken_d = 1'b0;
        end
        default: begin
          illegal_d = 1'b1;
        end
      endcase
    end
  end

  // state registers; all banks start idle since there is no other reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        bank_q[b] <= BK_IDLE;
      end
      tmr_q <= '0;
      dev_q <= DEV_NORMAL;
      devTmr_q <= TMR_ZERO;
      ckePrev_q <= 1'b0;
    end else begin
      bank_q <= bank_d;
      tmr_q <= tmr_d;
      dev_q <= dev_d;
      devTmr_q <= devTmr_d;
      ckePrev_q <= pinsSync.cke;
    end
  end

  // burst tracking and result pulses
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      burstAct_q <= 1'b0;
      burstBank_q <= '0;
      burstCnt_q <= BURST_ZERO;
      illegal_q <= 1'b0;
      taken_q <= 1'b0;
    end else begin
      burstAct_q <= burstAct_d;
      burstBank_q <= burstBank_d;
      burstCnt_q <= burstCnt_d;
      illegal_q <= illegal_d;
      taken_q <= taken_d;
    end
  end

  assign status = '{bankState: bank_q, devState: dev_q,
                    burstActive: burstAct_q, burstBank: burstBank_q};
  assign cmdIllegal = illegal_q;
  assign cmdTaken = taken_q;
endmodule : sdbc_bank_fsm
`default_nettype wire

/* dv/sdbc_bank_fsm_asserts.sv */
// sdbc_bank_fsm_asserts: port-level checks on the bank state tracker.
// Assumes one clock domain and a bind from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module sdbc_bank_fsm_asserts
  import sdbc_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic chipSelN, // chip select, active low
  input wire logic rowStrobeN, // row strobe, active low
  input wire logic colStrobeN, // column strobe, active low
  input wire logic writeEnN, // write enable, active low
  input wire logic cke, // clock enable
  input wire logic [sdbc_pkg::BANK_W-1:0] bankSelect, // bank_select
  input wire logic [sdbc_pkg::ADDR_W-1:0] addr, // address pins
  input wire sdbc_pkg::sdbc_status_t status, // tracked state
  input wire logic cmdIllegal, // illegal pulse
  input wire logic cmdTaken // accepted pulse
);
  import sdbc_pkg::*;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // inhibit or nop; answer lands three samples later (sync plus decision)
  logic quietCmd;
  assign quietCmd = chipSelN | (rowStrobeN & colStrobeN & writeEnN);

  pulse_excl_a: assert property (!(cmdTaken && cmdIllegal))
    else $error("taken and illegal pulses together");
  reset_idle_a: assert property ($fell(reset) |->
    status.bankState == {4{BK_IDLE}} && status.devState == DEV_NORMAL)
    else $error("state not idle after reset");
  nop_quiet_a: assert property (quietCmd |->
    ##3 (!cmdTaken && !cmdIllegal))
    else $error("pulse answered an inhibit or nop");
  burst_owner_a: assert property (status.burstActive |->
    status.bankState[status.burstBank] inside {BK_READING, BK_WRITING,
    BK_READ_AP, BK_WRITE_AP})
    else $error("burst bank not bursting");
  act_short_a: assert property (status.bankState[0] == BK_ACTIVATING
    |=> status.bankState[0] != BK_ACTIVATING)
    else $error("activating outlasted its delay");
  pre_idle_a: assert property (status.bankState[1] == BK_PRECHARGING
    |=> status.bankState[1] == BK_IDLE)
    else $error("precharge did not end idle");
  refresh_len_a: assert property ($rose(status.devState == DEV_REFRESH)
    |-> (status.devState == DEV_REFRESH) [*4] ##1
    status.devState == DEV_NORMAL)
    else $error("refresh length wrong");
  mode_len_a: assert property ($rose(status.devState == DEV_MODE_LOAD)
    |-> (status.devState == DEV_MODE_LOAD) [*2] ##1
    status.devState == DEV_NORMAL)
    else $error("mode load length wrong");
  preall_len_a: assert property ($rose(status.devState == DEV_PRE_ALL)
    |-> status.bankState == {4{BK_PRECHARGING}} ##1
    (status.devState == DEV_NORMAL && status.bankState == {4{BK_IDLE}}))
    else $error("precharge all wrong");
  // main scenarios reached
  cover property ($rose(status.burstActive));
  cover property ($rose(status.devState == DEV_REFRESH));
  cover property (cmdIllegal);
  cover property ($rose(status.devState == DEV_SELF_REFRESH));
endmodule : sdbc_bank_fsm_asserts
`default_nettype wire

/* dv/sdbc_ctrl_model.sv */
// sdbc_ctrl_model: memory controller side, drives the command pins.
// Assumes the testbench hands it one request per cycle when valid.
`timescale 1ns/1ps
`default_nettype none
module sdbc_ctrl_model
  import sdbc_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic reqValid, // a command is requested this cycle
  input wire sdbc_pkg::sdbc_pins_t reqPins, // requested pin values
  output var sdbc_pkg::sdbc_pins_t pins // command pins to the device
);
  import sdbc_pkg::*;

  logic idleSel_q = 1'b0;
  initial pins = PINS_RESET;
  // between commands only inhibit or nop, alternating
  // stale bank and address lines are inverted so nothing old lingers
  always @(posedge ref_clk) begin
    idleSel_q <= ~idleSel_q;
    if (reqValid) begin
      pins <= #1 reqPins;
    end else begin
      pins <= #1 {idleSel_q, 3'h7, 1'b1, ~pins.bankSelect, ~pins.addr};
    end
  end
endmodule : sdbc_ctrl_model
`default_nettype wire

/* dv/testbench.sv */
// testbench: drives commands through the controller model, scores the
// accept and illegal pulses and the tracked bank and device states.
// Assumes pins reach the state three edges after the model drives them.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin \
  errCount++; $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module testbench;
  import sdbc_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic reqValid = 1'b0;
  sdbc_pins_t reqPins = PINS_RESET;
  sdbc_pins_t pins;
  sdbc_status_t status;
  logic cmdIllegal;
  logic cmdTaken;
  logic [1:0] expP;
  logic [1:0] expQ[$];
  int errCount = 0;
  int nChecks = 0;
  integer seed = 32'h44381A1A;

  always #10 ref_clk = ~ref_clk;

  sdbc_ctrl_model partner (.ref_clk(ref_clk), .reqValid(reqValid),
    .reqPins(reqPins), .pins(pins));
  sdbc_bank_fsm uut (.ref_clk(ref_clk), .reset(reset),
    .chipSelN(pins.chipSelN), .rowStrobeN(pins.rowStrobeN),
    .colStrobeN(pins.colStrobeN), .writeEnN(pins.writeEnN),
    .cke(pins.cke), .bankSelect(pins.bankSelect), .addr(pins.addr),
    .status(status), .cmdIllegal(cmdIllegal), .cmdTaken(cmdTaken));

  task finishTest;
    begin
      $display("errors %0d checks %0d", errCount, nChecks);
      if (errCount == 0 && nChecks > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask : finishTest

  // one command for one cycle; expected pulse {taken, illegal} noted
  task issue(input logic [2:0] code, input logic [1:0] bank,
    input logic a10, input logic [1:0] exp, input logic ckeV);
    begin
      reqPins = {1'b0, code, ckeV, bank, a10, 10'($random(seed))};
      reqValid = 1'b1;
      if (exp != 2'h0) expQ.push_back(exp);
      @(posedge ref_clk);
      #1;
    end
  endtask : issue

  // idle n cycles; after issue, three reach the decided state
  task st(input int n);
    begin
      reqValid = 1'b0;
      repeat (n) begin
        @(posedge ref_clk);
        #1;
      end
    end
  endtask : st

  task chkSt(input logic [31:0] eb, input logic [5:0] ed);
    begin
      `CHK("bankState", eb, 32'(status.bankState))
      `CHK("devState", ed, 6'(status.devState))
    end
  endtask : chkSt

  // every pulse must match the oldest note, none may come unasked
  always @(posedge ref_clk) begin
    if (cmdTaken === 1'b1 || cmdIllegal === 1'b1) begin
      expP = (expQ.size() > 0) ? expQ.pop_front() : 2'h0;
      `CHK("pulses", expP, {cmdTaken, cmdIllegal})
    end
  end

  // watchdog: the sequence needs just over a hundred cycles
  initial begin
    repeat (2000) @(posedge ref_clk);
    errCount++;
    finishTest();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    #1 reset = 1'b0;
    st(2);
    chkSt({4{BK_IDLE}}, DEV_NORMAL);
    issue(CODE_PRE, 2'h0, 1'b0, 2'h2, 1'b1);
    issue(CODE_READ, 2'h2, 1'b0, 2'h1, 1'b1); // illegal on idle bank
    st(4);
    chkSt({4{BK_IDLE}}, DEV_NORMAL);
    issue(CODE_ACT, 2'h0, 1'b0, 2'h2, 1'b1);
    issue(CODE_READ, 2'h0, 1'b0, 2'h2, 1'b1);
    st(4);
    chkSt({BK_IDLE, BK_IDLE, BK_IDLE, BK_READING}, DEV_NORMAL);
    `CHK("burstActive", 1'b1, status.burstActive)
    `CHK("burstBank", 2'h0, status.burstBank)
    st(4);
    chkSt({BK_IDLE, BK_IDLE, BK_IDLE, BK_ROW_ACTIVE}, DEV_NORMAL);
    issue(CODE_READ, 2'h0, 1'b0, 2'h2, 1'b1);
    issue(CODE_WRITE, 2'h0, 1'b0, 2'h2, 1'b1);
    issue(CODE_STOP, 2'h0, 1'b0, 2'h2, 1'b1);
    st(4);
    chkSt({BK_IDLE, BK_IDLE, BK_IDLE, BK_ROW_ACTIVE}, DEV_NORMAL);
    `CHK("burstActive", 1'b0, status.burstActive)
    issue(CODE_WRITE, 2'h0, 1'b0, 2'h2, 1'b1);
    issue(CODE_READ, 2'h0, 1'b0, 2'h2, 1'b1);
    issue(CODE_PRE, 2'h0, 1'b0, 2'h2, 1'b1);
    st(3);
    chkSt({BK_IDLE, BK_IDLE, BK_IDLE, BK_PRECHARGING}, DEV_NORMAL);
    st(1);
    chkSt({4{BK_IDLE}}, DEV_NORMAL);
    issue(CODE_ACT, 2'h1, 1'b0, 2'h2, 1'b1);
    issue(CODE_ACT, 2'h0, 1'b0, 2'h2, 1'b1);
    issue(CODE_READ, 2'h1, 1'b1, 2'h2, 1'b1);
    issue(CODE_READ, 2'h0, 1'b0, 2'h2, 1'b1);
    st(3);
    chkSt({BK_IDLE, BK_IDLE, BK_PRECHARGING, BK_READING}, DEV_NORMAL);
    `CHK("burstBank", 2'h0, status.burstBank)
    st(1);
    chkSt({BK_IDLE, BK_IDLE, BK_IDLE, BK_READING}, DEV_NORMAL);
    issue(CODE_REF, 2'h0, 1'b0, 2'h1, 1'b1); // refused, bank 0 row still active
    st(8);
    issue(CODE_PRE, 2'h3, 1'b1, 2'h2, 1'b1);
    st(3);
    chkSt({4{BK_PRECHARGING}}, DEV_PRE_ALL);
    st(1);
    chkSt({4{BK_IDLE}}, DEV_NORMAL);
    issue(CODE_REF, 2'h0, 1'b0, 2'h2, 1'b1);
    issue(CODE_ACT, 2'h3, 1'b0, 2'h1, 1'b1); // refused while refreshing
    st(4);
    chkSt({4{BK_IDLE}}, DEV_REFRESH);
    st(3);
    chkSt({4{BK_IDLE}}, DEV_NORMAL);
    issue(CODE_LMR, 2'h0, 1'b0, 2'h2, 1'b1);
    st(4);
    chkSt({4{BK_IDLE}}, DEV_MODE_LOAD);
    st(2);
    chkSt({4{BK_IDLE}}, DEV_NORMAL);
    issue(CODE_REF, 2'h0, 1'b0, 2'h2, 1'b0); // enable low: self refresh
    st(3);
    chkSt({4{BK_IDLE}}, DEV_SELF_REFRESH);
    issue(CODE_ACT, 2'h1, 1'b0, 2'h1, 1'b1); // refused during exit
    chkSt({4{BK_IDLE}}, DEV_SR_EXIT);
    st(4);
    chkSt({4{BK_IDLE}}, DEV_NORMAL);
    issue(CODE_ACT, 2'h2, 1'b0, 2'h0, 1'b0); // clock enable low: ignored
    st(5);
    chkSt({4{BK_IDLE}}, DEV_NORMAL);
    issue(CODE_ACT, 2'h2, 1'b0, 2'h2, 1'b1);
    st(3);
    chkSt({BK_IDLE, BK_ACTIVATING, BK_IDLE, BK_IDLE}, DEV_NORMAL);
    st(8);
    `CHK("pending", 0, expQ.size())
    finishTest();
  end
endmodule : testbench

bind sdbc_bank_fsm sdbc_bank_fsm_asserts chk (.ref_clk(ref_clk),
  .reset(reset), .chipSelN(chipSelN), .rowStrobeN(rowStrobeN),
  .colStrobeN(colStrobeN), .writeEnN(writeEnN), .cke(cke),
  .bankSelect(bankSelect), .addr(addr), .status(status),
  .cmdIllegal(cmdIllegal), .cmdTaken(cmdTaken));
`default_nettype wire
